// [rtl/bidir_pulse_counter.sv]
// 16-bit up/down pulse counter with serial readout of the count
`timescale 1ns/1ns
`default_nettype none
`include "pulse_counter_cfg.svh"

module bidir_pulse_counter
  import pulse_counter_pkg::*;
(
  input  wire logic                    i_clock,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_pulse,
  input  wire logic                    i_count_up,
  input  wire logic                    i_clear,
  input  wire logic                    i_spi_select_n,
  input  wire logic                    i_spi_sclk,
  output logic                         o_spi_miso,
  output logic                         o_spi_miso_oe,
  output logic [`COUNT_WIDTH-1:0]      o_count
);

  top_state_t state;
  top_state_t next_state;

  count_stage_if upper_port ();
  count_stage_if lower_port ();

  logic count_pulse;
  logic select_fall;
  logic sclk_fall;

  // the pin is sampled on this clock, not used as one: a pulse must
  // stay low for a clock and high for a clock to be seen exactly once
  // one pulse event per rising edge of the pulse pin
  assign count_pulse = i_pulse && !state.pulse_prev;
  assign select_fall = !i_spi_select_n && state.select_prev;
  assign sclk_fall   = !i_spi_sclk && state.sclk_prev && !i_spi_select_n;

  // both stages share the pulse event
  assign lower_port.step = count_pulse;
  assign upper_port.step = count_pulse;

  assign lower_port.up = i_count_up;
  assign upper_port.up = i_count_up;

  assign lower_port.clear = i_clear;
  assign upper_port.clear = i_clear;

  assign lower_port.hold = 1'b0;

  // upper hold from inverted terminal flag
  // the upper stage sees every pulse event but only steps when the
  // lower stage sits at its terminal value for the chosen direction
  assign upper_port.hold = !lower_port.terminal;

  // lower byte of the count
  count_stage lower_count_stage (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .port      (lower_port.stage)
  );

  // upper byte of the count
  count_stage upper_count_stage (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .port      (upper_port.stage)
  );

  // count bytes joined upper then lower
  assign o_count = {upper_port.value, lower_port.value};

  // next state: edge memories and serial readout
  always_comb begin
    next_state             = state;
    next_state.pulse_prev  = i_pulse;
    next_state.sclk_prev   = i_spi_sclk;
    next_state.select_prev = i_spi_select_n;
    next_state.miso_oe     = !i_spi_select_n;
    // deselect abandons a readout in progress; the next select takes
    // a fresh snapshot, so a cut frame never leaves stale bits behind
    if (i_spi_select_n) begin
      next_state.miso      = 1'b0;
      next_state.bits_left = 5'h00;
    end else if (select_fall) begin
      next_state.shift     = {upper_port.value, lower_port.value};
      next_state.miso      = upper_port.value[`STAGE_WIDTH-1];
      next_state.bits_left = `SHIFT_BITS;
    end else if (sclk_fall && state.bits_left != 5'h00) begin
      next_state.shift     = {state.shift[`SHIFT_NEXT:0], 1'b0};
      next_state.miso      = state.shift[`SHIFT_NEXT];
      next_state.bits_left = 5'(state.bits_left - 5'h01);
    end
  end

  // state register
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state.pulse_prev  <= 1'b0;
      state.sclk_prev   <= 1'b0;
      state.select_prev <= 1'b1;
      state.shift       <= `COUNT_RESET;
      state.bits_left   <= 5'h00;
      state.miso        <= 1'b0;
      state.miso_oe     <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // serial outputs straight from flops
  assign o_spi_miso    = state.miso;
  assign o_spi_miso_oe = state.miso_oe;

  // clear zeroes the count on the next edge
  clear_zero_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_clear |=> (o_count == `COUNT_RESET))
    else $error("clear did not zero the count");

  // count up by one per pulse
  count_up_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (count_pulse && i_count_up && !i_clear)
      |=> (o_count == 16'($past(o_count) + 16'h0001)))
    else $error("up count wrong");

  // count down by one per pulse
  count_down_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (count_pulse && !i_count_up && !i_clear)
      |=> (o_count == 16'($past(o_count) - 16'h0001)))
    else $error("down count wrong");

  // lower byte moves on every pulse
  lower_step_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (count_pulse && !i_clear) |=> (lower_port.value != $past(lower_port.value)))
    else $error("lower stage missed a pulse");

  // no pulse, no change
  count_idle_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (!count_pulse && !i_clear) |=> $stable(o_count))
    else $error("count changed without a pulse");

  // upper byte only moves on carry or borrow
  upper_carry_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (count_pulse && !i_clear &&
     !((i_count_up && lower_port.value == `STAGE_TOP) ||
       (!i_count_up && lower_port.value == `STAGE_BOTTOM)))
      |=> (upper_port.value == $past(upper_port.value)))
    else $error("upper stage moved without carry");

  // upper hold tied to inverted terminal flag
  hold_link_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    upper_port.hold == !((i_count_up && lower_port.value == `STAGE_TOP) ||
                         (!i_count_up && lower_port.value == `STAGE_BOTTOM)))
    else $error("upper hold not linked to terminal flag");

  // snapshot taken at select and msb first
  snapshot_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    select_fall |=> (state.shift == $past(o_count)) &&
                    (o_spi_miso == $past(o_count[`SHIFT_MSB])))
    else $error("readout snapshot wrong");

  // pin driven while selected, released after
  miso_drive_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (!i_spi_select_n) |=> o_spi_miso_oe)
    else $error("readout pin not driven");

  // pin released and low once deselected
  miso_release_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_spi_select_n |=> (!o_spi_miso_oe && !o_spi_miso))
    else $error("readout pin not released");

  // second bit follows the first sclk fall
  shift_order_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (sclk_fall && state.bits_left != 5'h00)
      |=> (o_spi_miso == $past(state.shift[`SHIFT_NEXT])))
    else $error("readout shift order wrong");

  // carry into the upper byte when counting up from the top
  upper_carry_up_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (count_pulse && !i_clear && i_count_up && lower_port.value == `STAGE_TOP)
      |=> (upper_port.value == 8'($past(upper_port.value) + 8'h01)))
    else $error("upper stage missed a carry");

  // borrow from the upper byte when counting down from the bottom
  upper_borrow_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (count_pulse && !i_clear && !i_count_up && lower_port.value == `STAGE_BOTTOM)
      |=> (upper_port.value == 8'($past(upper_port.value) - 8'h01)))
    else $error("upper stage missed a borrow");

  // line idles low once all sixteen bits are out
  miso_done_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (!i_spi_select_n && !select_fall && state.bits_left == 5'h00) |=> !o_spi_miso)
    else $error("readout line not idle after last bit");

endmodule

`default_nettype wire

// [rtl/pulse_counter_cfg.svh]
// constants for the two-stage up/down pulse counter
`ifndef PULSE_COUNTER_CFG_SVH
`define PULSE_COUNTER_CFG_SVH

// width of one counting stage and of the whole count
`define STAGE_WIDTH      8
`define COUNT_WIDTH      16
// terminal values of a stage when counting up and down
`define STAGE_TOP        8'hFF
`define STAGE_BOTTOM     8'h00
// stage value after reset or clear
`define STAGE_RESET      8'h00
// whole count after reset or clear
`define COUNT_RESET      16'h0000
// serial readout length and shift bit positions
`define SHIFT_BITS       5'h10
`define SHIFT_MSB        15
`define SHIFT_NEXT       14

`endif

// [rtl/pulse_counter_pkg.sv]
// types shared by the pulse counter modules
`include "pulse_counter_cfg.svh"

package pulse_counter_pkg;

  // state of one 8-bit counting stage
  typedef struct packed {
    logic [`STAGE_WIDTH-1:0] value;
  } stage_state_t;

  // state of the counter top: edge memories and serial readout
  typedef struct packed {
    logic                    pulse_prev;
    logic                    sclk_prev;
    logic                    select_prev;
    logic [`COUNT_WIDTH-1:0] shift;
    logic [4:0]              bits_left;
    logic                    miso;
    logic                    miso_oe;
  } top_state_t;

endpackage

// [rtl/count_stage_if.sv]
// signals between the counter top and one counting stage
`timescale 1ns/1ns
`default_nettype none
`include "pulse_counter_cfg.svh"

interface count_stage_if;
  logic                    step;
  logic                    up;
  logic                    hold;
  logic                    clear;
  logic [`STAGE_WIDTH-1:0] value;
  logic                    terminal;

  modport stage (input step, up, hold, clear, output value, terminal);
  modport ctrl  (output step, up, hold, clear, input value, terminal);
endinterface

`default_nettype wire

// [rtl/count_stage.sv]
// one 8-bit up/down/hold counting stage with terminal-count flag
`timescale 1ns/1ns
`default_nettype none
`include "pulse_counter_cfg.svh"

module count_stage
  import pulse_counter_pkg::*;
(
  input  wire logic     i_clock,
  input  wire logic     i_reset_n,
  count_stage_if.stage  port
);

  stage_state_t state;
  stage_state_t next_state;

  always_comb begin
    next_state = state;
    if (port.clear) begin
      next_state.value = `STAGE_RESET;
    end else if (port.step && !port.hold) begin
      if (port.up) begin
        next_state.value = `STAGE_WIDTH'(state.value + 8'h01);
      end else begin
        next_state.value = `STAGE_WIDTH'(state.value - 8'h01);
      end
    end
  end

  // state register
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state.value <= `STAGE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign port.value = state.value;
  assign port.terminal = port.up ? (state.value == `STAGE_TOP)
                                 : (state.value == `STAGE_BOTTOM);

  // held stage keeps its value
  stage_hold_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (port.hold && !port.clear) |=> (port.value == $past(port.value)))
    else $error("held stage changed value");

  // terminal flag follows value and direction
  stage_terminal_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    port.terminal == ((port.up && port.value == `STAGE_TOP) ||
                      (!port.up && port.value == `STAGE_BOTTOM)))
    else $error("terminal flag wrong");

endmodule

`default_nettype wire

// [testbench/spi_host_model.sv]
// host side model that reads the 16-bit count over the serial port
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
  input  wire logic        i_clock,
  input  wire logic        i_start,
  input  wire logic        i_miso,
  input  wire logic        i_miso_oe,
  output logic             o_select_n,
  output logic             o_sclk,
  output logic [15:0]      o_data,
  output logic             o_done
);
  // a released line reads as the inverse of the current i_miso value
  logic                    miso_line;
  assign miso_line = i_miso_oe ? i_miso : !i_miso;

  // idle bus: deselected, serial clock still
  initial begin
    o_select_n = 1'b1;
    o_sclk = 1'b0;
    o_data = 16'h0000;
    o_done = 1'b0;
  end

  // whole count read: select, then 16 clock periods, sampling on each rise
  always @(posedge i_start) begin
    o_done = 1'b0;
    @(negedge i_clock) o_select_n = 1'b0;
    repeat (3) @(negedge i_clock);
    for (int i = 0; i < 16; i++) begin
      o_sclk = 1'b1;
      o_data = {o_data[14:0], miso_line};
      repeat (2) @(negedge i_clock);
      o_sclk = 1'b0;
      repeat (3) @(negedge i_clock);
    end
    o_select_n = 1'b1;
    o_done = 1'b1;
  end
endmodule

`default_nettype wire

// [testbench/bidir_16bit_pulse_counter_bench.sv]
// self-checking bench for the two-stage up/down pulse counter
`timescale 1ns/1ns
`default_nettype none

module bidir_16bit_pulse_counter_bench;
  typedef struct {
    logic        up;
    logic        clr;
    int          n;
    logic [15:0] exp;
  } row_t;

  logic        clock, reset_n, pulse, count_up, clear, start;
  logic        sel_n, sclk, miso, miso_oe, done;
  logic [15:0] count, data;
  int          n_fail, num_checks;
  // pulses applied in order from a zero count, with the count they leave
  row_t        rows [8] = '{
    '{1'b0, 1'b0, 1, 16'hFFFF}, '{1'b1, 1'b0, 1, 16'h0000},
    '{1'b1, 1'b0, 255, 16'h00FF}, '{1'b1, 1'b0, 1, 16'h0100},
    '{1'b0, 1'b0, 1, 16'h00FF}, '{1'b0, 1'b0, 255, 16'h0000},
    '{1'b1, 1'b0, 3, 16'h0003}, '{1'b1, 1'b1, 1, 16'h0000}};

  bidir_pulse_counter u_dut (
    .i_clock(clock), .i_reset_n(reset_n), .i_pulse(pulse), .i_count_up(count_up),
    .i_clear(clear), .i_spi_select_n(sel_n), .i_spi_sclk(sclk),
    .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .o_count(count));

  spi_host_model u_host (
    .i_clock(clock), .i_start(start), .i_miso(miso), .i_miso_oe(miso_oe), .o_select_n(sel_n),
    .o_sclk(sclk), .o_data(data), .o_done(done));

  always #2 clock = ~clock;

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one pin rise per call step, low and high for a cycle each
  task pulses(input int n);
    repeat (n) begin
      @(negedge clock) pulse = 1'b1;
      @(negedge clock) pulse = 1'b0;
    end
  endtask

  // watchdog against a hung handshake
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end

  // main sequence: table rows, then snapshot read and reset in mid-run
  initial begin
    clock = 1'b0; reset_n = 1'b0; pulse = 1'b0; count_up = 1'b1; clear = 1'b0; start = 1'b0;
    repeat (16) @(negedge clock);
    check("count in reset", count, 16'h0000);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      @(negedge clock);
      count_up = rows[i].up;
      clear = rows[i].clr;
      pulses(rows[i].n);
      @(negedge clock) clear = 1'b0;
      check("count", count, rows[i].exp);
      $display("row %0d done", i);
    end
    pulses(259);
    @(negedge clock) start = 1'b1;
    fork
      begin
        repeat (4) @(negedge clock);
        check("miso enable", {15'h0000, miso_oe}, 16'h0001);
        pulses(5);
      end
      wait (done);
    join
    check("read value", data, 16'h0103);
    check("count after read", count, 16'h0108);
    repeat (2) @(negedge clock);
    check("released miso", {14'h0000, miso_oe, miso}, 16'h0000);
    start = 1'b0;
    $display("snapshot read done");
    count_up = 1'b0;
    pulses(2);
    @(negedge clock) reset_n = 1'b0;
    #1 check("count at reset", count, 16'h0000);
    @(negedge clock) reset_n = 1'b1;
    pulses(1);
    check("count after reset", count, 16'hFFFF);
    $display("mid-run reset done");
    stop_test;
  end
endmodule

`default_nettype wire
